// ==== rtl/delay_pulse_timer.sv ====
// Top of the millisecond on-delay, off-delay and pulse timer
//
// Operation
// - On-delay: trigger high starts ms counting, running set, done low.
// - On-delay: elapsed reaching preset freezes it, clears running, sets done.
// - On-delay: trigger low clears elapsed, running and done.
// - On-delay: early trigger drop never raises done; elapsed returns to zero.
// - Off-delay: trigger high holds elapsed zero, running low, done high.
// - Off-delay: trigger low starts counting, running set, done stays high.
// - Off-delay: reaching preset freezes elapsed, clears running, drops done.
// - Off-delay: trigger back high early stops timing, zeroes, keeps done.
// - Pulse: trigger rise starts counting, running set, done high.
// - Pulse: preset reached with trigger high freezes elapsed, ends pulse.
// - Pulse: preset reached with trigger low zeroes elapsed, ends pulse.
// - Pulse: trigger drop before preset is ignored; pulse continues.
// - Pulse: trigger drop after preset zeroes elapsed, done stays low.
// - Pulse: power-flow output equals done output.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module delay_pulse_timer
   import dpt_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] elapsedMs,
   output logic runningFlag,
   output logic done,
   output logic powerFlow
);
   logic rstMeta_b;
   logic rstSync_b;
   logic [1:0] modeBits;
   mode_t mode;
   mode_t lastMode;
   logic trigger;
   logic trigPrev;
   logic [31:0] presetTime;
   logic tick;
   logic modeChange;
   logic reached;
   logic [31:0] next_elapsed;
   logic next_running;
   logic next_done;
   logic [31:0] rdData;
   logic rdErr;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_b <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_b <= 1'b1;
         rstSync_b <= rstMeta_b;
      end
   end

   apb_regs u_regs (
      .mclk(mclk),
      .rstSync_b(rstSync_b),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .elapsedMs(elapsedMs),
      .statusBits({powerFlow, runningFlag, done}),
      .prdata(rdData),
      .pslverr(rdErr),
      .mode(modeBits),
      .trigger(trigger),
      .presetTime(presetTime)
   );

   assign mode = mode_t'(modeBits);
   assign modeChange = (mode != lastMode);

   // Prescaler restarts whenever a timing run is not in progress, so the
   // first tick after a start lands one full millisecond later
   ms_prescaler #(
      .CYCLES(TICK_LEN)
   ) u_presc (
      .mclk(mclk),
      .rstSync_b(rstSync_b),
      .clear(!runningFlag),
      .tick(tick)
   );

   // Data and error are registered in the setup cycle so both stand with pready
   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= rdData;
         pslverr <= rdErr;
      end else begin
         pslverr <= 1'b0;
      end
   end

   // Setup cycle registers the answer, so the access is always zero wait
   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         trigPrev <= 1'b0;
         lastMode <= on_delay_mode;
      end else begin
         trigPrev <= trigger;
         lastMode <= mode;
      end
   end

   assign reached = (elapsedMs + 32'h00000001 >= presetTime);

   always_comb begin
      next_elapsed = elapsedMs;
      next_running = runningFlag;
      next_done = done;
      case (mode)
         on_delay_mode: begin
            if (!trigger) begin
               next_elapsed = 32'h00000000;
               next_running = 1'b0;
               next_done = 1'b0;
            end else if (done) begin
               next_running = 1'b0;
            end else if (presetTime == 32'h00000000) begin
               next_running = 1'b0;
               next_done = 1'b1;
            end else if (!runningFlag) begin
               next_running = 1'b1;
               next_done = 1'b0;
            end else if (tick) begin
               if (reached) begin
                  next_elapsed = presetTime;
                  next_running = 1'b0;
                  next_done = 1'b1;
               end else begin
                  next_elapsed = elapsedMs + 32'h00000001;
               end
            end
         end
         off_delay_mode: begin
            if (trigger) begin
               next_elapsed = 32'h00000000;
               next_running = 1'b0;
               next_done = 1'b1;
            end else if (!done) begin
               next_running = 1'b0;
            end else if (!runningFlag) begin
               if (trigPrev) begin
                  next_running = 1'b1;
               end else begin
                  next_done = 1'b0;
               end
            end else if (tick) begin
               if (reached) begin
                  next_elapsed = presetTime;
                  next_running = 1'b0;
                  next_done = 1'b0;
               end else begin
                  next_elapsed = elapsedMs + 32'h00000001;
               end
            end
         end
         pulse_mode: begin
            if (runningFlag) begin
               if (tick) begin
                  if (reached) begin
                     next_running = 1'b0;
                     next_done = 1'b0;
                     next_elapsed = trigger ? presetTime : 32'h00000000;
                  end else begin
                     next_elapsed = elapsedMs + 32'h00000001;
                  end
               end
            end else if (trigger && !trigPrev) begin
               next_elapsed = 32'h00000000;
               next_running = (presetTime != 32'h00000000);
               next_done = (presetTime != 32'h00000000);
            end else if (!trigger) begin
               next_elapsed = 32'h00000000;
               next_done = 1'b0;
            end
         end
         default: begin
            next_elapsed = 32'h00000000;
            next_running = 1'b0;
            next_done = 1'b0;
         end
      endcase
      if (modeChange) begin
         next_elapsed = 32'h00000000;
         next_running = 1'b0;
         next_done = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         elapsedMs <= 32'h00000000;
         runningFlag <= 1'b0;
         done <= 1'b0;
      end else begin
         elapsedMs <= next_elapsed;
         runningFlag <= next_running;
         done <= next_done;
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         powerFlow <= 1'b0;
      end else begin
         powerFlow <= next_done;
      end
   end

   property p_on_drop;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == on_delay_mode && !modeChange && !trigger)
         |=> (elapsedMs == 32'h0 && !done && !runningFlag);
   endproperty
   a_on_drop: assert property (p_on_drop)
      else $error("on-delay did not clear on trigger drop");

   property p_on_done;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == on_delay_mode && $rose(done)) |-> elapsedMs == presetTime;
   endproperty
   a_on_done: assert property (p_on_done)
      else $error("on-delay done rose away from preset");

   property p_on_run;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == on_delay_mode && runningFlag) |-> !done;
   endproperty
   a_on_run: assert property (p_on_run)
      else $error("on-delay done high while running");

   property p_off_hold;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == off_delay_mode && !modeChange && trigger)
         |=> (done && !runningFlag && elapsedMs == 32'h0);
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("off-delay not holding with trigger high");

   property p_off_end;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == off_delay_mode && $fell(done) && $past(runningFlag))
         |-> elapsedMs == presetTime;
   endproperty
   a_off_end: assert property (p_off_end)
      else $error("off-delay ended away from preset");

   property p_tick_only;
      @(posedge mclk) disable iff (!rstSync_b)
      (elapsedMs == $past(elapsedMs) + 32'h1) |-> $past(tick);
   endproperty
   a_tick_only: assert property (p_tick_only)
      else $error("elapsed advanced without a tick");

   property p_pulse_run;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == pulse_mode && runningFlag && !tick && !modeChange)
         |=> runningFlag && done;
   endproperty
   a_pulse_run: assert property (p_pulse_run)
      else $error("pulse ended without a tick");

   property p_flow;
      @(posedge mclk) disable iff (!rstSync_b)
      mode == pulse_mode |-> powerFlow == done;
   endproperty
   a_flow: assert property (p_flow)
      else $error("power flow differs from done");

   property p_off_start;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == off_delay_mode && !modeChange && !trigger && $past(trigger)
         && done) |=> (runningFlag && done);
   endproperty
   a_off_start: assert property (p_off_start)
      else $error("off-delay did not start timing on trigger drop");

   property p_off_abort;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == off_delay_mode && !modeChange && trigger && runningFlag)
         |=> (!runningFlag && done && elapsedMs == 32'h0);
   endproperty
   a_off_abort: assert property (p_off_abort)
      else $error("off-delay did not abort on early trigger");

   property p_pulse_start;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == pulse_mode && !modeChange && !runningFlag && $rose(trigger)
         && presetTime != 32'h0) |=> (runningFlag && done);
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("pulse did not start on trigger rise");

   property p_pulse_hold;
      @(posedge mclk) disable iff (!rstSync_b)
      ($past(mode) == pulse_mode && !$past(modeChange) && $fell(runningFlag)
         && $past(trigger)) |-> (elapsedMs == $past(presetTime) && !done);
   endproperty
   a_pulse_hold: assert property (p_pulse_hold)
      else $error("pulse end with trigger high not held at preset");

   property p_pulse_zero;
      @(posedge mclk) disable iff (!rstSync_b)
      ($past(mode) == pulse_mode && !$past(modeChange) && $fell(runningFlag)
         && !$past(trigger)) |-> (elapsedMs == 32'h0 && !done);
   endproperty
   a_pulse_zero: assert property (p_pulse_zero)
      else $error("pulse end with trigger low not zeroed");

   property p_pulse_idle;
      @(posedge mclk) disable iff (!rstSync_b)
      (mode == pulse_mode && !modeChange && !runningFlag && !trigger)
         |=> (elapsedMs == 32'h0 && !done);
   endproperty
   a_pulse_idle: assert property (p_pulse_idle)
      else $error("pulse idle with trigger low not cleared");

   property p_reset_clear;
      @(posedge mclk)
      !rstSync_b |-> (elapsedMs == 32'h0 && !runningFlag && !done && !tick);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("state not cleared during reset");
endmodule
`default_nettype wire

// ==== rtl/dpt_pkg.sv ====
// Constants, register map and types for the delay and pulse timer
package dpt_pkg;
   localparam int MCLK_HZ = 25000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = MCLK_HZ / 1000 * TICK_MS;
   localparam int PRESC_W = 15;
   localparam int TIME_W = 32;
   localparam logic [11:0] CTRL_OFFS = 12'h000;
   localparam logic [11:0] PRESET_OFFS = 12'h004;
   localparam logic [11:0] ELAPSED_OFFS = 12'h008;
   localparam logic [11:0] STATUS_OFFS = 12'h00c;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TRIG_BIT = 2;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   localparam int STAT_FLOW_BIT = 2;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [31:0] PRESET_RESET = 32'h00000000;
   typedef enum logic [1:0] {
      on_delay_mode,
      off_delay_mode,
      pulse_mode,
      mode_spare
   } mode_t;
endpackage

// ==== rtl/ms_prescaler.sv ====
// Millisecond tick generator for the delay and pulse timer
`timescale 1ns/10ps
`default_nettype none
module ms_prescaler
   import dpt_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rstSync_b,
   input wire logic clear,
   output logic tick
);
   logic [PRESC_W-1:0] count;
   localparam logic [PRESC_W-1:0] LAST = PRESC_W'(CYCLES - 1);

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         count <= '0;
         tick <= 1'b0;
      end else if (clear) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick <= 1'b1;
      end else begin
         count <= count + PRESC_W'(1);
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/apb_regs.sv ====
// APB slave decode for the delay and pulse timer registers
`timescale 1ns/10ps
`default_nettype none
module apb_regs
   import dpt_pkg::*;
(
   input wire logic mclk,
   input wire logic rstSync_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] elapsedMs,
   input wire logic [2:0] statusBits,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic [1:0] mode,
   output logic trigger,
   output logic [31:0] presetTime
);
   logic access;
   assign access = psel && penable;

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         mode <= MODE_RESET;
         trigger <= 1'b0;
         presetTime <= PRESET_RESET;
      end else if (access && pwrite) begin
         if (paddr == CTRL_OFFS) begin
            mode <= pwdata[CTRL_MODE_LSB +: 2];
            trigger <= pwdata[CTRL_TRIG_BIT];
         end else if (paddr == PRESET_OFFS) begin
            presetTime <= pwdata;
         end
      end
   end

   // Read data is combinational so the top can register it in the setup cycle
   always_comb begin
      prdata = 32'h00000000;
      pslverr = 1'b0;
      if (paddr == CTRL_OFFS) begin
         prdata[CTRL_MODE_LSB +: 2] = mode;
         prdata[CTRL_TRIG_BIT] = trigger;
      end else if (paddr == PRESET_OFFS) begin
         prdata = presetTime;
      end else if (paddr == ELAPSED_OFFS) begin
         prdata = elapsedMs;
      end else if (paddr == STATUS_OFFS) begin
         prdata[2:0] = statusBits;
      end else begin
         pslverr = psel;
      end
   end
endmodule
`default_nettype wire

// ==== tb/dpt_ctrl_model.sv ====
// Control-side APB master that sets the trigger level and preset time
`timescale 1ns/10ps
`default_nettype none
module dpt_ctrl_model (
   input wire logic mclk,
   input wire logic pready,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h00000000;
   end
   // Called just after a rising edge; the request stays up until pready
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
   endtask
   // Kept apart from xfer so back-to-back setups never double-assign psel
   task automatic rel(input int n);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== tb/delay_pulse_timer_tb.sv ====
// Self-checking bench for the delay and pulse timer
`timescale 1ns/10ps
`default_nettype none
module delay_pulse_timer_tb;
   import dpt_pkg::*;
   localparam int TL = 4;
   typedef struct packed {
      logic isRd;
      logic [31:0] data;
      logic err;
   } note_t;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, runningFlag, done;
   logic powerFlow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, elapsedMs;
   note_t notes[$];
   note_t nt;
   int n_errors = 0;
   int tests_run = 0;
   int p;
   always #20 mclk = ~mclk;
   dpt_ctrl_model dpt_ctrl_model_i (.mclk(mclk), .pready(pready),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata));
   delay_pulse_timer #(.TICK_LEN(TL)) delay_pulse_timer_i (.mclk(mclk),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .elapsedMs(elapsedMs),
      .runningFlag(runningFlag), .done(done), .powerFlow(powerFlow));
   task automatic wrap_up();
      $display("errors %0d, checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmpResp(input note_t n);
      tests_run++;
      if (pslverr !== n.err || (n.isRd && prdata !== n.data)) begin
         n_errors++;
         $display("unexpected at %0t: addr %h read %h err %b", $time,
                  paddr, prdata, pslverr);
      end
   endtask
   function automatic logic unmapped(input logic [11:0] a);
      return !(a inside {CTRL_OFFS, PRESET_OFFS, ELAPSED_OFFS, STATUS_OFFS});
   endfunction
   function automatic logic [31:0] st(input logic run, input logic dn);
      return {29'h0, dn, run, dn};
   endfunction
   // Scoreboard: every completed transfer retires the oldest note
   always @(posedge mclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (notes.size() == 0) begin
            n_errors++;
            $display("unexpected at %0t: response with no request", $time);
         end else begin
            nt = notes.pop_front();
            cmpResp(nt);
         end
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      notes.push_back('{1'b0, d, unmapped(a)});
      dpt_ctrl_model_i.xfer(1'b1, a, d);
      dpt_ctrl_model_i.rel(1 + $urandom % 2);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic hold = 1'b0);
      notes.push_back('{1'b1, unmapped(a) ? 32'h0 : e, unmapped(a)});
      dpt_ctrl_model_i.xfer(1'b0, a, 32'h0);
      if (!hold) begin
         dpt_ctrl_model_i.rel(1 + $urandom % 2);
      end
   endtask
   task automatic ctl(input logic [1:0] m, input logic t);
      wr(CTRL_OFFS, {29'h0, t, m});
   endtask
   task automatic waitMs(input int n);
      repeat (n * TL + 12) @(posedge mclk);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up();
   end
   initial begin
      void'($urandom(32'h92c0a793));
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(ELAPSED_OFFS, 32'h0);
      rd(STATUS_OFFS, 32'h0);
      rd(PRESET_OFFS, PRESET_RESET);
      rd(12'h010, 32'h0, 1'b1);
      rd(CTRL_OFFS, 32'h0);
      wr(12'h020, 32'h5);
      rd(PRESET_OFFS, PRESET_RESET);
      p = 2 + $urandom % 4;
      wr(PRESET_OFFS, p);
      ctl(on_delay_mode, 1'b1);
      rd(STATUS_OFFS, st(1, 0));
      waitMs(p);
      rd(ELAPSED_OFFS, p);
      rd(STATUS_OFFS, st(0, 1));
      ctl(on_delay_mode, 1'b0);
      rd(ELAPSED_OFFS, 32'h0);
      rd(STATUS_OFFS, 32'h0);
      wr(PRESET_OFFS, 32'd20);
      ctl(on_delay_mode, 1'b1);
      repeat (40) @(posedge mclk);
      rd(STATUS_OFFS, st(1, 0));
      ctl(on_delay_mode, 1'b0);
      rd(ELAPSED_OFFS, 32'h0);
      rd(STATUS_OFFS, 32'h0);
      wr(PRESET_OFFS, 32'd3);
      ctl(off_delay_mode, 1'b1);
      rd(ELAPSED_OFFS, 32'h0);
      rd(STATUS_OFFS, st(0, 1));
      ctl(off_delay_mode, 1'b0);
      rd(STATUS_OFFS, st(1, 1));
      waitMs(3);
      rd(ELAPSED_OFFS, 32'd3);
      rd(STATUS_OFFS, 32'h0);
      wr(PRESET_OFFS, 32'd20);
      ctl(off_delay_mode, 1'b1);
      ctl(off_delay_mode, 1'b0);
      rd(STATUS_OFFS, st(1, 1));
      ctl(off_delay_mode, 1'b1);
      rd(STATUS_OFFS, st(0, 1));
      rd(ELAPSED_OFFS, 32'h0);
      wr(PRESET_OFFS, 32'd3);
      ctl(pulse_mode, 1'b0);
      ctl(pulse_mode, 1'b1);
      rd(STATUS_OFFS, st(1, 1));
      waitMs(3);
      rd(ELAPSED_OFFS, 32'd3);
      rd(STATUS_OFFS, 32'h0);
      ctl(pulse_mode, 1'b0);
      rd(ELAPSED_OFFS, 32'h0);
      rd(STATUS_OFFS, 32'h0);
      wr(PRESET_OFFS, 32'd6);
      ctl(pulse_mode, 1'b1);
      ctl(pulse_mode, 1'b0);
      rd(STATUS_OFFS, st(1, 1));
      waitMs(6);
      rd(ELAPSED_OFFS, 32'h0);
      rd(STATUS_OFFS, 32'h0);
      wr(PRESET_OFFS, 32'h0);
      ctl(on_delay_mode, 1'b1);
      repeat (2) @(posedge mclk);
      rd(STATUS_OFFS, st(0, 1));
      ctl(mode_spare, 1'b1);
      rd(STATUS_OFFS, 32'h0);
      wr(PRESET_OFFS, 32'd20);
      ctl(on_delay_mode, 1'b1);
      repeat (12) @(posedge mclk);
      rd(STATUS_OFFS, st(1, 0));
      // Mid-run reset while the on-delay is timing
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(ELAPSED_OFFS, 32'h0);
      rd(STATUS_OFFS, 32'h0);
      rd(CTRL_OFFS, 32'h0);
      repeat (2) @(posedge mclk);
      wrap_up();
   end
endmodule
`default_nettype wire
